// File: dsr_defines.svh
// Named constants for the digital input source router
`ifndef DSR_DEFINES_SVH
`define DSR_DEFINES_SVH
// ====================================================================
// Table geometry
`define DSR_SEL_COUNT 36
`define DSR_WORD_WIDTH 32
`define DSR_EXT_WIDTH 4
`define DSR_HIGHEST_SUB 8'h24
`define DSR_SEL_RESET 8'h00
`define DSR_SUB_COUNT 8'h00
`define DSR_SUB_FIRST 8'h01
`define DSR_RDATA_RESET 8'h00
// ====================================================================
// Source codes (bit 7 is the invert flag)
`define DSR_INV_BIT 7
`define DSR_CODE_ZERO 7'h00
`define DSR_PHYS_FIRST 7'h01
`define DSR_PHYS_LAST 7'h10
`define DSR_AUX_FIRST 7'h41
`define DSR_AUX_LAST 7'h50
// ====================================================================
// Source widths and special-function bit positions
`define DSR_PHYS_WIDTH 16
`define DSR_AUX_WIDTH 16
`define DSR_SYNC_WIDTH 32
`define DSR_BIT_NEG_LIMIT 0
`define DSR_BIT_POS_LIMIT 1
`define DSR_BIT_HOME 2
`endif

// File: dsr_pkg.sv
// Types shared by the digital input source router files
package dsr_pkg;
  typedef logic [7:0] dsr_code_type;
  typedef logic [7:0] dsr_sub_type;
  typedef logic [15:0] dsr_src16_type;
endpackage

// File: dsr_src_if.sv
// Filtered source lines handed from the router top to each bit picker
interface dsr_src_if;
  dsr_pkg::dsr_src16_type phys;
  dsr_pkg::dsr_src16_type aux;
  modport drive (output phys, output aux);
  modport pick (input phys, input aux);
endinterface

// File: dsr_bit_pick.sv
// One routed bit: decodes a source code and picks the source line
module dsr_bit_pick
  import dsr_pkg::*;
(
  // Sources
  dsr_src_if.pick src,
  // Selector code and routed bit
  input wire dsr_pkg::dsr_code_type code_i,
  output logic bit_o
);
  import dsr_pkg::*;
`include "dsr_defines.svh"

  // ==================================================================
  // Decode function
  function automatic logic dsr_pick(input dsr_code_type code, input dsr_src16_type phys,
                                    input dsr_src16_type aux);
    logic [6:0] sel;
    logic raw;
    logic ok;
    sel = code[6:0];
    raw = 1'b0;
    ok = 1'b0;
    if (sel == `DSR_CODE_ZERO) begin
      ok = 1'b1;
    end else if (sel >= `DSR_PHYS_FIRST && sel <= `DSR_PHYS_LAST) begin
      raw = phys[4'(sel - `DSR_PHYS_FIRST)];
      ok = 1'b1;
    end else if (sel >= `DSR_AUX_FIRST && sel <= `DSR_AUX_LAST) begin
      raw = aux[4'(sel - `DSR_AUX_FIRST)];
      ok = 1'b1;
    end
    // Undefined codes read low whatever the invert flag says
    return ok & (raw ^ code[`DSR_INV_BIT]);
  endfunction

  // Invert flag on bit 7 covers constants and every source
  always_comb begin
    bit_o = dsr_pick(code_i, src.phys, src.aux);
  end
endmodule

// File: dsr_router.sv
// Digital input source router: selector table, input sync and word build
module dsr_router
  import dsr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Object dictionary entry access
  input wire dsr_pkg::dsr_sub_type od_sub_i,
  input wire logic od_wr_i,
  input wire logic od_rd_i,
  input wire dsr_pkg::dsr_code_type od_wdata_i,
  output logic [7:0] od_rdata_o,
  output logic od_rvalid_o,
  output logic od_err_o,
  // Raw source pins
  input wire logic [15:0] phys_in_i,
  input wire logic [2:0] hall_i,
  input wire logic [2:0] enc_i,
  input wire logic usb_power_i,
  input wire logic eth_active_i,
  input wire logic [7:0] dip_i,
  // Routed results
  output logic [31:0] digital_input_word_o,
  output logic [3:0] routed_ext_o,
  output logic neg_limit_o,
  output logic pos_limit_o,
  output logic home_o
);
  import dsr_pkg::*;
`include "dsr_defines.svh"

  // ==================================================================
  // Declarations
  // Selector table, index 0 serves entry 1
  dsr_code_type sel_q [`DSR_SEL_COUNT];
  // Synchroniser stages and agreed levels
  logic [`DSR_SYNC_WIDTH-1:0] raw_pins;
  logic [`DSR_SYNC_WIDTH-1:0] sync1_q;
  logic [`DSR_SYNC_WIDTH-1:0] sync2_q;
  logic [`DSR_SYNC_WIDTH-1:0] sync3_q;
  logic [`DSR_SYNC_WIDTH-1:0] filt_q;
  // Picker results and access decode
  logic [`DSR_SEL_COUNT-1:0] routed;
  logic sub_in_table;
  logic [5:0] sub_idx;
  logic [7:0] rdata_d;
  logic rd_bad;
  logic wr_bad;

  // Filtered sources shared by every picker
  dsr_src_if src_bus ();

  // ==================================================================
  // Entry address decode
  // Entry 0 is the count, entries 1 to 36 the selectors
  function automatic logic dsr_sub_ok(input dsr_sub_type sub);
    return (sub >= `DSR_SUB_FIRST) && (sub <= `DSR_HIGHEST_SUB);
  endfunction

  // Table index of an entry; only meaningful when the entry is in the table
  function automatic logic [5:0] dsr_sub_index(input dsr_sub_type sub);
    return 6'(sub - `DSR_SUB_FIRST);
  endfunction

  // Selector index from the entry number, first entry is index zero
  always_comb begin
    sub_in_table = dsr_sub_ok(od_sub_i);
    sub_idx = dsr_sub_index(od_sub_i);
  end

  // ==================================================================
  // Selector table, preset on reset, writes to the count entry ignored
  // Only the addressed entry moves; a read in the same cycle sees the old code
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < `DSR_SEL_COUNT; i++) begin
        sel_q[i] <= `DSR_SEL_RESET;
      end
    end else if (od_wr_i && sub_in_table) begin
      sel_q[sub_idx] <= od_wdata_i;
    end
  end

  // Read data mux: count entry, selectors, zero for unmapped
  always_comb begin
    rdata_d = `DSR_RDATA_RESET;
    if (od_sub_i == `DSR_SUB_COUNT) begin
      rdata_d = `DSR_HIGHEST_SUB;
    end else if (sub_in_table) begin
      rdata_d = sel_q[sub_idx];
    end
  end

  // Refused accesses: reads past the table, writes to the count or past it
  always_comb begin
    rd_bad = od_rd_i && !sub_in_table && (od_sub_i != `DSR_SUB_COUNT);
    wr_bad = od_wr_i && !sub_in_table;
  end

  // Read strobe echoed one cycle later as the valid pulse
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      od_rvalid_o <= 1'b0;
    end else begin
      od_rvalid_o <= od_rd_i;
    end
  end

  // Read data loads only on a read and holds between reads
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      od_rdata_o <= `DSR_RDATA_RESET;
    end else if (od_rd_i) begin
      od_rdata_o <= rdata_d;
    end
  end

  // One-cycle error pulse for a refused access
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      od_err_o <= 1'b0;
    end else begin
      od_err_o <= rd_bad || wr_bad;
    end
  end

  // ==================================================================
  // Pin synchronisers: three stages, a change counts once stages 2 and 3 agree
  // Aux order: Hall U,V,W, encoder A,B,index, USB power, link, DIP 1-8
  // Stage 1 may go metastable, so only stages 2 and 3 are ever compared
  // A single-sample glitch never reaches the pickers
  // Cost: a pin change takes five edges to show in the word
  always_comb begin
    raw_pins = {dip_i, eth_active_i, usb_power_i, enc_i, hall_i, phys_in_i};
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= raw_pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Per-line agreement filter
  // A line whose stages disagree keeps its last agreed level
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      filt_q <= '0;
    end else begin
      for (int i = 0; i < `DSR_SYNC_WIDTH; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          filt_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // Hand filtered lines to the pickers
  assign src_bus.phys = filt_q[`DSR_PHYS_WIDTH-1:0];
  assign src_bus.aux = filt_q[`DSR_SYNC_WIDTH-1:`DSR_PHYS_WIDTH];

  // ==================================================================
  // One picker per selector
  // Every picker sees the same sources; only its code differs
  for (genvar g = 0; g < `DSR_SEL_COUNT; g++) begin : g_pick
    dsr_bit_pick u_pick (
      .src(src_bus),
      .code_i(sel_q[g]),
      .bit_o(routed[g])
    );
  end

  // ==================================================================
  // Registered word, one bit per selector 1 to 32
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      digital_input_word_o <= '0;
    end else begin
      digital_input_word_o <= routed[`DSR_WORD_WIDTH-1:0];
    end
  end

  // Selectors 33 to 36 have no word bit, so their results leave here
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      routed_ext_o <= '0;
    end else begin
      routed_ext_o <= routed[`DSR_SEL_COUNT-1:`DSR_WORD_WIDTH];
    end
  end

  // Limit and home switches follow their routed word bits
  // Taken from the same routed bits, so the special view never lags the word
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      neg_limit_o <= 1'b0;
      pos_limit_o <= 1'b0;
      home_o <= 1'b0;
    end else begin
      neg_limit_o <= routed[`DSR_BIT_NEG_LIMIT];
      pos_limit_o <= routed[`DSR_BIT_POS_LIMIT];
      home_o <= routed[`DSR_BIT_HOME];
    end
  end
endmodule

// File: dsr_router_props.sv
// Checker for the router's access port and routed word
// ====
// Port checks
module dsr_router_props (
  // Clock, reset and access port
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire dsr_pkg::dsr_sub_type od_sub_i,
  input wire logic od_wr_i,
  input wire logic od_rd_i,
  input wire dsr_pkg::dsr_code_type od_wdata_i,
  input wire logic [7:0] od_rdata_o,
  input wire logic od_rvalid_o,
  input wire logic od_err_o,
  // Routed word
  input wire logic [31:0] digital_input_word_o
);
  import dsr_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Refused accesses and constant-low codes
  wire err_w = (od_rd_i && od_sub_i > 8'h24) || (od_wr_i && (od_sub_i == 8'h00 || od_sub_i > 8'h24));
  wire wr_w = od_wr_i && od_sub_i >= 8'h01 && od_sub_i <= 8'h20;
  wire lo_w = od_wdata_i == 8'h00 || od_wdata_i[6:0] > 7'h50
    || (od_wdata_i[6:0] > 7'h10 && od_wdata_i[6:0] < 7'h41);
  AST_RVALID: assert property (od_rvalid_o == $past(od_rd_i))
    else $error("read valid not one cycle after read");
  AST_COUNT: assert property (od_rd_i && od_sub_i == 8'h00 |=> od_rdata_o == 8'h24)
    else $error("count entry wrong");
  AST_ERR: assert property (od_err_o == $past(err_w))
    else $error("error pulse wrong");
  AST_OOR_ZERO: assert property (od_rd_i && od_sub_i > 8'h24 |=> od_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_HOLD: assert property (!od_rd_i |=> $stable(od_rdata_o))
    else $error("read data moved without read");
  AST_RESET: assert property ($fell(rst_i) |-> digital_input_word_o == 32'h0000_0000)
    else $error("word not clear after reset");
  AST_HIGH: assert property (wr_w && od_wdata_i == 8'h80 ##1 !od_wr_i [*2]
    |=> digital_input_word_o[$past(od_sub_i, 3) - 1]) else $error("code 80 not high");
  AST_LOW: assert property (wr_w && lo_w ##1 !od_wr_i [*2]
    |=> !digital_input_word_o[$past(od_sub_i, 3) - 1]) else $error("low code not low");
  // Main scenarios
  cover property (od_rvalid_o);
  cover property (od_err_o);
  cover property (od_wr_i && od_wdata_i == 8'h80);
endmodule
bind dsr_router dsr_router_props dsr_router_props_inst (.ref_clk_i, .rst_i, .od_sub_i,
  .od_wr_i, .od_rd_i, .od_wdata_i, .od_rdata_o, .od_rvalid_o, .od_err_o, .digital_input_word_o);

// File: dsr_pin_model.sv
// Switch, sensor, encoder and Hall lines feeding the router
module dsr_pin_model (
  // Clock and new levels
  input wire logic ref_clk_i,
  input wire logic load_i,
  input wire logic [31:0] val_i,
  // Levels: phys 15:0, Hall 18:16, encoder 21:19, USB 22, link 23, DIP 31:24
  output logic [31:0] pins_o
);
  // ====
  // Lines hold their level until the bench moves them
  initial pins_o = 32'h0000_0000;
  always @(posedge ref_clk_i) begin
    if (load_i) begin
      pins_o <= val_i;
    end
  end
endmodule

// File: testbench.sv
// Self-checking bench for the digital input source router
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dsr_pkg::*;
  // ====
  // Stimulus and observed signals
  logic ref_clk_i = 0, rst_i = 1, od_wr_i = 0, od_rd_i = 0, load = 0;
  dsr_sub_type od_sub_i = 8'h00;
  dsr_code_type od_wdata_i = 8'h00;
  dsr_code_type codes [36];
  logic [31:0] val = 32'h0000_0000, pins, word;
  logic [7:0] od_rdata_o;
  logic [3:0] ext;
  logic od_rvalid_o, od_err_o, nl, pl, hm;
  int bad_count = 0, n_tests = 0;
  // 200 MHz clock
  always #2.5 ref_clk_i = ~ref_clk_i;
  dsr_pin_model dsr_pin_model_inst (.ref_clk_i, .load_i(load), .val_i(val), .pins_o(pins));
  dsr_router dsr_router_inst (.ref_clk_i, .rst_i, .od_sub_i, .od_wr_i, .od_rd_i, .od_wdata_i,
    .od_rdata_o, .od_rvalid_o, .od_err_o, .phys_in_i(pins[15:0]), .hall_i(pins[18:16]),
    .enc_i(pins[21:19]), .usb_power_i(pins[22]), .eth_active_i(pins[23]), .dip_i(pins[31:24]),
    .digital_input_word_o(word), .routed_ext_o(ext), .neg_limit_o(nl), .pos_limit_o(pl),
    .home_o(hm));
  // Expected routed bit for a code and pin levels
  function automatic logic exp_bit(dsr_code_type c, logic [31:0] p);
    logic [6:0] s;
    s = c[6:0];
    if (s >= 7'h01 && s <= 7'h10) return p[s - 1] ^ c[7];
    if (s >= 7'h41 && s <= 7'h50) return p[s - 7'h31] ^ c[7];
    return s == 7'h00 && c[7];
  endfunction
  // Compare and count
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // Write strobe stays up for back-to-back writes
  task automatic wr(dsr_sub_type s, dsr_code_type d);
    @(posedge ref_clk_i);
    od_wr_i <= 1;
    od_sub_i <= s;
    od_wdata_i <= d;
  endtask
  // Read one entry and compare
  task automatic rd(dsr_sub_type s, logic [7:0] e);
    @(posedge ref_clk_i);
    od_rd_i <= 1;
    od_sub_i <= s;
    @(posedge ref_clk_i);
    od_rd_i <= 0;
    #1 chk("rdata", od_rdata_o, e);
    chk("rvalid", od_rvalid_o, 1);
    chk("rd err", od_err_o, s > 8'h24);
  endtask
  // Verdict
  task automatic stop_test();
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
  // Main sequence: code sweep, then random rounds
  initial begin
    void'($urandom(31));
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 0;
    rd(8'h00, 8'h24);
    rd(8'h25, 8'h00);
    wr(8'h00, 8'h55);
    wr(8'h25, 8'h80);
    @(posedge ref_clk_i) od_wr_i <= 0;
    #1 chk("wr err", od_err_o, 1);
    rd(8'h00, 8'h24);
    rd(8'h07, 8'h00);
    for (int r = 0; r < 20; r++) begin
      for (int i = 0; i < 36; i++) codes[i] = r < 8 ? 8'(r * 36 + i) : 8'($urandom);
      if (r == 8) codes[0] = 8'h80;
      for (int i = 35; i >= 0; i--) wr(8'(i + 1), codes[i]);
      @(posedge ref_clk_i);
      od_wr_i <= 0;
      val <= $urandom;
      load <= 1;
      @(posedge ref_clk_i);
      load <= 0;
      repeat (8) @(posedge ref_clk_i);
      #1 for (int i = 0; i < 32; i++) chk("word", word[i], exp_bit(codes[i], val));
      for (int i = 0; i < 4; i++) chk("ext", ext[i], exp_bit(codes[32 + i], val));
      chk("limits", {hm, pl, nl}, {exp_bit(codes[2], val), exp_bit(codes[1], val),
        exp_bit(codes[0], val)});
      for (int i = 0; i < 36; i += 7) rd(8'(i + 1), codes[i]);
    end
    @(posedge ref_clk_i) rst_i <= 1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 0;
    rd(8'h24, 8'h00);
    chk("rst word", word, 32'h0000_0000);
    stop_test();
  end
endmodule
